// ### hdl/decoder_status_pkg.sv
/*
  Register map, field positions and reset values of the decoder status and
  interrupt-enable block.
  Assumes the sub-address decoding of the two-wire control interface happens
  outside and hands over one 8-bit sub-address per access.
*/
package decoder_status_pkg;

  // Data and address widths of the register port.
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned IRQ_W  = 8;

  // Sub-addresses.
  localparam logic [7:0] VBI_DETECT_STATUS_ADDR = 8'h0c;
  localparam logic [7:0] VIDEO_LOCK_STATUS_ADDR = 8'h0e;
  localparam logic [7:0] IRQ_ENABLE_MASK_ADDR   = 8'h0f;
  localparam logic [7:0] IRQ_STATUS_ADDR        = 8'h10;

  // Reset values.
  localparam logic [7:0] VBI_DETECT_STATUS_RST = 8'h00;
  localparam logic [7:0] VIDEO_LOCK_STATUS_RST = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_MASK_RST   = 8'h00;
  localparam logic [7:0] IRQ_STATUS_RST        = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE   = 8'h00;

  // Detection register fields.
  localparam int unsigned CC_ODD_BIT    = 7;
  localparam int unsigned CC_EVEN_BIT   = 6;
  localparam int unsigned WSS_ODD_BIT   = 5;
  localparam int unsigned WSS_EVEN_BIT  = 4;
  localparam int unsigned TELETEXT_BIT  = 3;

  // Video status register fields.
  localparam int unsigned VLOCK_BIT     = 7;
  localparam int unsigned HLOCK_BIT     = 6;
  localparam int unsigned CLOCK_BIT     = 5;
  localparam int unsigned PRESENT_BIT   = 4;
  localparam int unsigned CP_LSB        = 1;
  localparam int unsigned CP_W          = 3;
  localparam int unsigned STD_BIT       = 0;

  // Interrupt cause positions, shared by mask and status.
  localparam int unsigned IRQ_GENLOCK_LOSS = 7;
  localparam int unsigned IRQ_SIGNAL_LOSS  = 6;
  localparam int unsigned IRQ_CC_DATA      = 5;
  localparam int unsigned IRQ_WSS_DATA     = 4;
  localparam int unsigned IRQ_TELETEXT     = 3;
  localparam int unsigned IRQ_COPY_PROTECT = 2;
  localparam int unsigned IRQ_STD_DETECT   = 1;
  localparam int unsigned IRQ_FIELD_START  = 0;

endpackage : decoder_status_pkg

// ### hdl/irq_flag_if.sv
/*
  Carrier between the status block and its sticky flag bank.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface irq_flag_if #(parameter int unsigned W = 8);
  logic [W-1:0] set_pulse;
  logic [W-1:0] clear_bits;
  logic [W-1:0] flags;

  modport bank (input set_pulse, input clear_bits, output flags);
  modport ctrl (output set_pulse, output clear_bits, input flags);
endinterface : irq_flag_if

// ### hdl/level_edge_detect.sv
/*
  Rising and falling edge detector for a vector of levels.
  Assumes the levels are synchronous to the clock.
*/
`timescale 1ns/1ps
module level_edge_detect #(
  parameter int unsigned W = 1
) (
  // Clock and reset.
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // Levels in, edges out.
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] prev;

  if (W < 1) begin : g_bad_width
    $error("level_edge_detect needs W of at least one");
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) prev <= '0;
    else        prev <= level;
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule : level_edge_detect

// ### hdl/irq_flag_bank.sv
/*
  Bank of sticky interrupt flags, set by hardware and cleared by writing one.
  Assumes the controller presents set and clear as one-cycle pulses.
*/
`timescale 1ns/1ps
module irq_flag_bank #(
  parameter int unsigned W = 8
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Flag traffic.
  irq_flag_if.bank fb
);
  if (W < 1) begin : g_bad_width
    $error("irq_flag_bank needs W of at least one");
  end

  // A set in the same cycle as its clear wins, so no event is lost.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) fb.flags <= '0;
    else        fb.flags <= fb.set_pulse | (fb.flags & ~fb.clear_bits);
  end
endmodule : irq_flag_bank

// ### hdl/decoder_status.sv
/*
  Status and interrupt-enable registers of the video decoder: VBI detection
  status, video lock status, interrupt enable mask and the write-one-to-clear
  interrupt status, with the interrupt request output.
  Assumes a two-wire interface slave outside that turns each host access into
  one sub-address with a single-cycle read or write strobe, and that all
  detector inputs are synchronous to ref_clk.
*/
// Behaviour
// - Detection and video status bits ignore writes.
// - Bit 7 shows odd-field caption detect.
// - Bit 6 shows even-field caption detect.
// - Bit 5 shows odd-field widescreen detect.
// - Bit 4 shows even-field widescreen detect.
// - Bit 3 shows teletext detect; 2-0 reserved.
// - Video bit 7 shows vertical lock.
// - Video bit 6 shows horizontal lock.
// - Video bit 5 shows chroma lock.
// - Video bit 4 shows input video present.
// - Bits 3-1 show read-only copy-protect code.
// - Video bit 0 shows standard determined.
// - Standard bit only when auto-detect enabled.
// - Mask bit 7 enables genlock loss interrupt.
// - Mask bit 6 enables signal loss interrupt.
// - Mask bit 5 enables caption data interrupt.
// - Mask bit 4 enables widescreen data interrupt.
// - Mask bit 3 enables teletext field interrupt.
// - Mask bit 2 enables copy-protect change interrupt.
// - Mask bit 1 enables standard detected interrupt.
// - Mask bit 0 enables field start interrupt.
// - Status bits at 10h set, cleared by one.
`timescale 1ns/1ps
module decoder_status (
  // Clock and reset.
  input  wire logic                                    ref_clk,
  input  wire logic                                    rst_n,
  // Sub-addressed register port.
  input  wire logic [decoder_status_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic                                    reg_wr,
  input  wire logic [decoder_status_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                                    reg_rd,
  output logic      [decoder_status_pkg::DATA_W-1:0]   reg_rdata,
  output logic                                         reg_rd_valid,
  // VBI slicer detection levels.
  input  wire logic                                    cc_odd_detect,
  input  wire logic                                    cc_even_detect,
  input  wire logic                                    wss_odd_detect,
  input  wire logic                                    wss_even_detect,
  input  wire logic                                    teletext_detect,
  // VBI new-data and field pulses.
  input  wire logic                                    cc_data_strobe,
  input  wire logic                                    wss_data_strobe,
  input  wire logic                                    teletext_field_strobe,
  input  wire logic                                    field_start,
  // Lock loops, input detector, copy-protect and standard detectors.
  input  wire logic                                    vertical_lock,
  input  wire logic                                    horizontal_lock,
  input  wire logic                                    chroma_lock,
  input  wire logic                                    video_present,
  input  wire logic [decoder_status_pkg::CP_W-1:0]     copy_protect,
  input  wire logic                                    standard_detected,
  // Auto-detect enable from the input format register.
  input  wire logic                                    auto_detect_enable,
  // Interrupt request.
  output logic                                         irq_request
);
  import decoder_status_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [DATA_W-1:0] vbi_detect_status;
  logic [DATA_W-1:0] video_lock_status;
  logic [IRQ_W-1:0]  irq_enable_mask;
  logic [CP_W-1:0]   copy_protect_prev;
  logic [IRQ_W-1:0]  irq_events;
  logic              std_report;
  logic              genlock;
  logic [2:0]        lvl_rise;
  logic [2:0]        lvl_fall;
  logic              wr_vbi;
  logic              wr_video;
  logic              wr_mask;
  logic              wr_irq_status;
  logic [DATA_W-1:0] next_rdata;

  irq_flag_if #(.W(IRQ_W)) flag_bus ();

  assign wr_vbi        = reg_wr && (reg_addr == VBI_DETECT_STATUS_ADDR);
  assign wr_video      = reg_wr && (reg_addr == VIDEO_LOCK_STATUS_ADDR);
  assign wr_mask       = reg_wr && (reg_addr == IRQ_ENABLE_MASK_ADDR);
  assign wr_irq_status = reg_wr && (reg_addr == IRQ_STATUS_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Read-only status registers follow their detectors every cycle.
  // Writes to them are decoded but steer nothing, so host data is discarded.

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      vbi_detect_status <= VBI_DETECT_STATUS_RST;
    end else begin
      vbi_detect_status               <= '0;
      vbi_detect_status[CC_ODD_BIT]   <= cc_odd_detect;
      vbi_detect_status[CC_EVEN_BIT]  <= cc_even_detect;
      vbi_detect_status[WSS_ODD_BIT]  <= wss_odd_detect;
      vbi_detect_status[WSS_EVEN_BIT] <= wss_even_detect;
      vbi_detect_status[TELETEXT_BIT] <= teletext_detect;
    end
  end

  // The standard bit is withheld unless auto-detection is switched on.
  assign std_report = standard_detected && auto_detect_enable;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      video_lock_status <= VIDEO_LOCK_STATUS_RST;
    end else begin
      video_lock_status[VLOCK_BIT]               <= vertical_lock;
      video_lock_status[HLOCK_BIT]               <= horizontal_lock;
      video_lock_status[CLOCK_BIT]               <= chroma_lock;
      video_lock_status[PRESENT_BIT]             <= video_present;
      video_lock_status[CP_LSB +: CP_W]          <= copy_protect;
      video_lock_status[STD_BIT]                 <= std_report;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt enable mask, the only register the host can store into.

  always_ff @(posedge ref_clk) begin
    if (!rst_n)       irq_enable_mask <= IRQ_ENABLE_MASK_RST;
    else if (wr_mask) irq_enable_mask <= reg_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event sources. Genlock counts as held only with both sync locks, so
  // losing either one is a loss of genlock.

  assign genlock = vertical_lock && horizontal_lock;

  level_edge_detect #(.W(3)) u_level_edges (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .level   ({genlock, video_present, std_report}),
    .rise    (lvl_rise),
    .fall    (lvl_fall)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_n) copy_protect_prev <= '0;
    else        copy_protect_prev <= copy_protect;
  end

  always_comb begin
    irq_events                   = '0;
    irq_events[IRQ_GENLOCK_LOSS] = lvl_fall[2];
    irq_events[IRQ_SIGNAL_LOSS]  = lvl_fall[1];
    irq_events[IRQ_CC_DATA]      = cc_data_strobe;
    irq_events[IRQ_WSS_DATA]     = wss_data_strobe;
    irq_events[IRQ_TELETEXT]     = teletext_field_strobe;
    irq_events[IRQ_COPY_PROTECT] = copy_protect != copy_protect_prev;
    irq_events[IRQ_STD_DETECT]   = lvl_rise[0];
    irq_events[IRQ_FIELD_START]  = field_start;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status flags; a one written at 10h clears that flag.

  assign flag_bus.set_pulse  = irq_events;
  assign flag_bus.clear_bits = wr_irq_status ? reg_wdata : '0;

  irq_flag_bank #(.W(IRQ_W)) u_flags (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .fb      (flag_bus)
  );

  // The request lags the flags by one cycle so that it leaves a flip-flop.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) irq_request <= 1'b0;
    else        irq_request <= |(flag_bus.flags & irq_enable_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path. Unmapped sub-addresses read as zero.

  always_comb begin
    case (reg_addr)
      VBI_DETECT_STATUS_ADDR: next_rdata = vbi_detect_status;
      VIDEO_LOCK_STATUS_ADDR: next_rdata = video_lock_status;
      IRQ_ENABLE_MASK_ADDR:   next_rdata = irq_enable_mask;
      IRQ_STATUS_ADDR:        next_rdata = flag_bus.flags;
      default:                next_rdata = UNMAPPED_READ_VALUE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata    <= '0;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd;
      if (reg_rd) reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_vbi_write;
    wr_vbi;
  endsequence

  sequence s_video_write;
    wr_video;
  endsequence

  sequence s_clear_only(int unsigned b);
    wr_irq_status && reg_wdata[b] && !irq_events[b];
  endsequence

  property p_vbi_ignores_write;
    s_vbi_write |=> vbi_detect_status == {$past(cc_odd_detect), $past(cc_even_detect),
                    $past(wss_odd_detect), $past(wss_even_detect),
                    $past(teletext_detect), 3'h0};
  endproperty
  a_vbi_ignores_write: assert property (p_vbi_ignores_write)
    else $error("vbi status took a host write");

  property p_vbi_tracks;
    ##1 vbi_detect_status[7:3] == {$past(cc_odd_detect), $past(cc_even_detect),
        $past(wss_odd_detect), $past(wss_even_detect), $past(teletext_detect)};
  endproperty
  a_vbi_tracks: assert property (p_vbi_tracks)
    else $error("vbi status bits do not follow detectors");

  property p_reserved_zero;
    vbi_detect_status[2:0] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved vbi bits not zero");

  property p_video_ignores_write;
    s_video_write |=> video_lock_status[CP_LSB +: CP_W] == $past(copy_protect)
                      && video_lock_status[VLOCK_BIT] == $past(vertical_lock);
  endproperty
  a_video_ignores_write: assert property (p_video_ignores_write)
    else $error("video status took a host write");

  property p_locks_track;
    ##1 video_lock_status[7:4] == {$past(vertical_lock), $past(horizontal_lock),
        $past(chroma_lock), $past(video_present)};
  endproperty
  a_locks_track: assert property (p_locks_track)
    else $error("lock bits do not follow the lock loops");

  property p_std_gated;
    !auto_detect_enable |=> !video_lock_status[STD_BIT];
  endproperty
  a_std_gated: assert property (p_std_gated)
    else $error("standard bit shown with auto-detect off");

  property p_std_shown;
    standard_detected && auto_detect_enable |=> video_lock_status[STD_BIT];
  endproperty
  a_std_shown: assert property (p_std_shown)
    else $error("standard bit missing");

  property p_mask_write;
    wr_mask |=> irq_enable_mask == $past(reg_wdata);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write not stored");

  property p_event_sets_flag;
    irq_events[IRQ_FIELD_START] |=> flag_bus.flags[IRQ_FIELD_START];
  endproperty
  a_event_sets_flag: assert property (p_event_sets_flag)
    else $error("field start did not set its flag");

  property p_cp_change;
    copy_protect != $past(copy_protect) |=> flag_bus.flags[IRQ_COPY_PROTECT];
  endproperty
  a_cp_change: assert property (p_cp_change)
    else $error("copy-protect change did not set its flag");

  property p_genlock_loss;
    $fell(genlock) |=> flag_bus.flags[IRQ_GENLOCK_LOSS];
  endproperty
  a_genlock_loss: assert property (p_genlock_loss)
    else $error("genlock loss did not set its flag");

  property p_signal_loss;
    $fell(video_present) |=> flag_bus.flags[IRQ_SIGNAL_LOSS];
  endproperty
  a_signal_loss: assert property (p_signal_loss)
    else $error("signal loss did not set its flag");

  property p_strobes;
    cc_data_strobe |=> flag_bus.flags[IRQ_CC_DATA];
  endproperty
  a_strobes: assert property (p_strobes)
    else $error("caption strobe did not set its flag");

  property p_wss_strobe;
    wss_data_strobe |=> flag_bus.flags[IRQ_WSS_DATA];
  endproperty
  a_wss_strobe: assert property (p_wss_strobe)
    else $error("widescreen strobe did not set its flag");

  property p_teletext_strobe;
    teletext_field_strobe |=> flag_bus.flags[IRQ_TELETEXT];
  endproperty
  a_teletext_strobe: assert property (p_teletext_strobe)
    else $error("teletext strobe did not set its flag");

  property p_std_event;
    $rose(std_report) |=> flag_bus.flags[IRQ_STD_DETECT];
  endproperty
  a_std_event: assert property (p_std_event)
    else $error("standard detection did not set its flag");

  property p_w1c;
    s_clear_only(IRQ_FIELD_START) |=> !flag_bus.flags[IRQ_FIELD_START];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write of one did not clear the flag");

  property p_set_wins;
    wr_irq_status && reg_wdata[IRQ_FIELD_START] && field_start
      |=> flag_bus.flags[IRQ_FIELD_START];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a simultaneous set");

  property p_irq;
    ##1 irq_request == |($past(flag_bus.flags) & $past(irq_enable_mask));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request does not match flags and mask");

  property p_read;
    reg_rd && reg_addr == IRQ_ENABLE_MASK_ADDR
      |=> reg_rd_valid && reg_rdata == $past(irq_enable_mask);
  endproperty
  a_read: assert property (p_read)
    else $error("mask read returned wrong data");

endmodule : decoder_status

// ### test/decoder_status_bench.sv
/*
  Self-checking bench of the decoder status block: status registers, mask,
  sticky interrupt flags and the interrupt request.
  Assumes the design package is compiled first and drives every input itself
  at the falling edge of ref_clk.
*/
`timescale 1ns/1ps
module decoder_status_bench;
  import decoder_status_pkg::*;
  //////////////////////////////////////////////////////////////////////////
  logic       ref_clk;
  logic       rst_n;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       reg_rd_valid;
  logic       cc_odd_detect;
  logic       cc_even_detect;
  logic       wss_odd_detect;
  logic       wss_even_detect;
  logic       teletext_detect;
  logic       cc_data_strobe;
  logic       wss_data_strobe;
  logic       teletext_field_strobe;
  logic       field_start;
  logic       vertical_lock;
  logic       horizontal_lock;
  logic       chroma_lock;
  logic       video_present;
  logic [2:0] copy_protect;
  logic       standard_detected;
  logic       auto_detect_enable;
  logic       irq_request;
  int         n_mismatch;
  int         n_compared;
  int         cycles;

  decoder_status uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .cc_odd_detect(cc_odd_detect),
    .cc_even_detect(cc_even_detect), .wss_odd_detect(wss_odd_detect),
    .wss_even_detect(wss_even_detect), .teletext_detect(teletext_detect),
    .cc_data_strobe(cc_data_strobe), .wss_data_strobe(wss_data_strobe),
    .teletext_field_strobe(teletext_field_strobe), .field_start(field_start),
    .vertical_lock(vertical_lock), .horizontal_lock(horizontal_lock),
    .chroma_lock(chroma_lock), .video_present(video_present),
    .copy_protect(copy_protect), .standard_detected(standard_detected),
    .auto_detect_enable(auto_detect_enable), .irq_request(irq_request)
  );

  //////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // The whole run needs a few hundred cycles; the ceiling leaves wide margin.
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      n_mismatch = n_mismatch + 1;
      final_report();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  task automatic irq_is(input logic e, input string name);
    check(name, {7'h00, irq_request}, {7'h00, e});
  endtask : irq_is

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : idle

  // Each access first lets an edge pass, so a strobe is never lowered and
  // raised again in one time step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    check("read valid", {7'h00, reg_rd_valid}, 8'h01);
    check(name, reg_rdata, exp);
  endtask : rd

  // One event of cause i (two for copy-protect, set then cleared), and only that cause.
  task automatic fire(input int i);
    @(negedge ref_clk);
    case (i)
      7: {vertical_lock, horizontal_lock} = 2'b11;
      6: video_present = 1'b1;
      5: cc_data_strobe = 1'b1;
      4: wss_data_strobe = 1'b1;
      3: teletext_field_strobe = 1'b1;
      2: copy_protect = 3'h5;
      1: {auto_detect_enable, standard_detected} = 2'b11;
      default: field_start = 1'b1;
    endcase
    @(negedge ref_clk);
    {vertical_lock, horizontal_lock, video_present, copy_protect} = 6'h00;
    {cc_data_strobe, wss_data_strobe, teletext_field_strobe} = 3'h0;
    {field_start, standard_detected} = 2'b00;
  endtask : fire

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(VBI_DETECT_STATUS_ADDR, 8'h00, "vbi status reset");
    rd(VIDEO_LOCK_STATUS_ADDR, 8'h00, "video status reset");
    rd(IRQ_ENABLE_MASK_ADDR, 8'h00, "mask reset");
    rd(IRQ_STATUS_ADDR, 8'h00, "irq status reset");
    rd(8'h20, UNMAPPED_READ_VALUE, "unmapped read");
    irq_is(1'b0, "irq after reset");
  endtask : t_reset

  task automatic t_vbi();
    for (int i = 0; i < 5; i++) begin
      {cc_odd_detect, cc_even_detect, wss_odd_detect, wss_even_detect,
       teletext_detect} = 5'h10 >> i;
      rd(VBI_DETECT_STATUS_ADDR, 8'h80 >> i, "vbi bit");
    end
    {cc_odd_detect, cc_even_detect, wss_odd_detect, wss_even_detect, teletext_detect} = 5'h1f;
    wr(VBI_DETECT_STATUS_ADDR, 8'h07);
    rd(VBI_DETECT_STATUS_ADDR, 8'hf8, "vbi write ignored");
    {cc_odd_detect, cc_even_detect, wss_odd_detect, wss_even_detect, teletext_detect} = 5'h00;
  endtask : t_vbi

  task automatic t_video();
    {vertical_lock, horizontal_lock, chroma_lock, video_present} = 4'hf;
    standard_detected = 1'b1;
    rd(VIDEO_LOCK_STATUS_ADDR, 8'hf0, "standard without auto");
    wr(VIDEO_LOCK_STATUS_ADDR, 8'h0f);
    rd(VIDEO_LOCK_STATUS_ADDR, 8'hf0, "video write ignored");
    auto_detect_enable = 1'b1;
    for (int c = 0; c < 8; c++) begin
      copy_protect = c[2:0];
      rd(VIDEO_LOCK_STATUS_ADDR, 8'hf1 | {4'h0, c[2:0], 1'b0}, "copy protect code");
    end
    {vertical_lock, horizontal_lock, chroma_lock, video_present} = 4'h0;
    {copy_protect, standard_detected, auto_detect_enable} = 5'h00;
    idle(4);
    wr(IRQ_STATUS_ADDR, 8'hff);
    rd(IRQ_STATUS_ADDR, 8'h00, "flags cleared");
  endtask : t_video

  task automatic t_mask();
    wr(IRQ_ENABLE_MASK_ADDR, 8'ha5);
    rd(IRQ_ENABLE_MASK_ADDR, 8'ha5, "mask a5");
    wr(IRQ_ENABLE_MASK_ADDR, 8'h5a);
    rd(IRQ_ENABLE_MASK_ADDR, 8'h5a, "mask 5a");
  endtask : t_mask

  // Every cause is raised once with its mask bit off, then enabled, cleared.
  task automatic t_causes();
    for (int i = 0; i < 8; i++) begin
      wr(IRQ_ENABLE_MASK_ADDR, ~(8'h01 << i));
      fire(i);
      idle(4);
      irq_is(1'b0, "irq masked out");
      rd(IRQ_STATUS_ADDR, 8'h01 << i, "cause flag");
      wr(IRQ_ENABLE_MASK_ADDR, 8'h01 << i);
      idle(2);
      irq_is(1'b1, "irq enabled");
      wr(IRQ_STATUS_ADDR, 8'h01 << i);
      idle(2);
      irq_is(1'b0, "irq after clear");
      rd(IRQ_STATUS_ADDR, 8'h00, "flag after clear");
    end
    auto_detect_enable = 1'b0;
  endtask : t_causes

  // A new event in the clearing cycle must survive, and clearing one flag
  // must leave the request up while another enabled flag stands.
  task automatic t_set_wins();
    wr(IRQ_ENABLE_MASK_ADDR, 8'h21);
    fire(5);
    @(negedge ref_clk);
    reg_addr = IRQ_STATUS_ADDR;
    reg_wdata = 8'h01;
    reg_wr = 1'b1;
    field_start = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    field_start = 1'b0;
    idle(2);
    rd(IRQ_STATUS_ADDR, 8'h21, "set beats clear");
    wr(IRQ_STATUS_ADDR, 8'h01);
    idle(2);
    irq_is(1'b1, "irq with one flag left");
    wr(IRQ_STATUS_ADDR, 8'h20);
    idle(2);
    irq_is(1'b0, "irq with no flag left");
  endtask : t_set_wins

  //////////////////////////////////////////////////////////////////////////
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    cycles = 0;
    rst_n = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h00000;
    {cc_odd_detect, cc_even_detect, wss_odd_detect, wss_even_detect, teletext_detect} = 5'h00;
    {cc_data_strobe, wss_data_strobe, teletext_field_strobe, field_start} = 4'h0;
    {vertical_lock, horizontal_lock, chroma_lock, video_present} = 4'h0;
    {copy_protect, standard_detected, auto_detect_enable} = 5'h00;
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    t_reset();
    t_vbi();
    t_video();
    t_mask();
    t_causes();
    t_set_wins();
    final_report();
  end
endmodule : decoder_status_bench
